// ===== core/dma_tf_pkg.sv
// Purpose: Shared constants for the DMA bus setup and drive register bridge
// Assumes: Register indices are word indices; byte address is four times
// Notes:   PIO phase times are plain defaults, counts derive from core_clk
package dma_tf_pkg;

  // Register indices
  localparam logic [7:0]  IDX_DMA_CFG     = 8'h38;
  localparam logic [7:0]  IDX_STATUS      = 8'h3a;
  localparam logic [7:0]  IDX_HW_CFG      = 8'h3c;
  localparam logic [7:0]  IDX_TF_DATA     = 8'h40;
  localparam logic [7:0]  IDX_TF_CMD      = 8'h44;

  // Hardware configuration fields and reset value
  localparam int          HW_ENDIAN_HI    = 7;
  localparam int          HW_ENDIAN_LO    = 6;
  localparam int          HW_EOT_LVL      = 5;
  localparam int          HW_MASTER       = 4;
  localparam int          HW_ACK_LVL      = 3;
  localparam int          HW_REQ_LVL      = 2;
  localparam int          HW_WR_LVL       = 1;
  localparam int          HW_RD_LVL       = 0;
  localparam logic [7:0]  HW_CFG_RESET    = 8'h04;
  localparam logic [1:0]  ENDIAN_SWAPPED  = 2'h1;

  // DMA configuration fields and reset value
  localparam int          CFG_WIDTH16     = 0;
  localparam int          CFG_CORE_MODE   = 13;
  localparam logic [15:0] DMA_CFG_RESET   = 16'h0000;

  // Drive register window values
  localparam logic [7:0]  CMD_READ_VALUE  = 8'hff;
  localparam logic [7:0]  TF_DATA_RESET   = 8'h00;

  // PIO phase timing
  localparam int          CLK_MHZ         = 50;
  localparam int          PIO_SETUP_NS    = 100;
  localparam int          PIO_STROBE_NS   = 300;
  localparam int          PIO_RECOVER_NS  = 200;
  localparam logic [7:0]  PIO_SETUP_CYC   =
    8'((PIO_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0]  PIO_STROBE_CYC  =
    8'((PIO_STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0]  PIO_RECOVER_CYC =
    8'((PIO_RECOVER_NS * CLK_MHZ + 999) / 1000);

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_SETUP   = 4'b0010,
    ST_STROBE  = 4'b0100,
    ST_RECOVER = 4'b1000
  } pio_state_t;

  // Index to {valid, select hi_n, select lo_n, addr[2:0]}
  function automatic logic [5:0] tf_pins(input logic [7:0] idx);
    case (idx)
      8'h40:   tf_pins = 6'b1_10_000;
      8'h48:   tf_pins = 6'b1_10_001;
      8'h49:   tf_pins = 6'b1_10_010;
      8'h4a:   tf_pins = 6'b1_10_011;
      8'h4b:   tf_pins = 6'b1_10_100;
      8'h4c:   tf_pins = 6'b1_10_101;
      8'h4d:   tf_pins = 6'b1_10_110;
      8'h44:   tf_pins = 6'b1_10_111;
      8'h4e:   tf_pins = 6'b1_01_110;
      8'h4f:   tf_pins = 6'b1_01_111;
      default: tf_pins = 6'b0_11_000;
    endcase
  endfunction

  // Exchange the two bytes of a bus word
  function automatic logic [15:0] swap16(input logic [15:0] w);
    swap16 = {w[7:0], w[15:8]};
  endfunction

endpackage

// ===== core/dma_tf_bridge.sv
// Purpose: DMA bus polarity/role/byte order setup and PIO drive registers
// Assumes: Avalon-MM slave with registered waitrequest; 8-bit host data
// Notes:   Drive access holds the host until the PIO cycle has finished
// Contract
// R01: One-byte bus setup register at 3Ch with swap, end, role, four levels.
// R02: Swap code 00 keeps high byte on upper lane; 01 exchanges lanes.
// R03: Swapping applies only during slave or master DMA transfers.
// R04: Software keeps swap code 00 with an 8-bit DMA bus.
// R05: Bit 5 sets end-of-transfer level; honoured only in slave DMA.
// R06: Bit 4 picks slave DMA (0) or master DMA (1).
// R07: Bit 3 sets acknowledge level, 0 low, 1 high.
// R08: Bit 2 sets request level, resets to 1; others reset 0.
// R09: Bit 1 sets drive write strobe level.
// R10: Bit 0 sets drive read strobe level.
// R11: Command-started PIO always moves 16 bits.
// R12: Host accesses to 40h-4Fh become drive PIO cycles.
// R13: Each drive register has fixed select and address pin values.
// R14: Drive register map follows ATA usage, data register 16 bits.
// R15: Data register needs two host accesses per PIO cycle, low first.
// R16: Other drive registers take one access, one PIO cycle.
// R17: Software writes the command register last.
// R18: Data window at 40h is 8-bit read/write, resets to zero.
// R19: Software selects disk core mode before drive register access.
// R20: Request pin undriven until DMA configuration is written once.
// R21: Command register reads return FFh and start no drive cycle.
// R22: Reserved swap codes behave as normal byte order.
// R23: Host access pends until the PIO cycle ends; reads return drive data.
`timescale 1ns/1ns
`default_nettype none
module dma_tf_bridge
  import dma_tf_pkg::*;
#(
  parameter logic [7:0] SETUP_CYC   = PIO_SETUP_CYC,
  parameter logic [7:0] STROBE_CYC  = PIO_STROBE_CYC,
  parameter logic [7:0] RECOVER_CYC = PIO_RECOVER_CYC
) (
  // Clock and resets
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        bus_reset,
  // Avalon-MM register slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  // DMA engine side
  input  wire logic        xfer_dma_active,
  input  wire logic        eng_req,
  input  wire logic        eng_ack,
  input  wire logic        eng_rd,
  input  wire logic        eng_wr,
  input  wire logic        eng_out_en,
  input  wire logic [15:0] eng_out_data,
  output var  logic [15:0] buf_in_data,
  output var  logic        eot_seen,
  output var  logic        ack_seen,
  output var  logic        master_mode,
  output var  logic        width16,
  output var  logic        disk_core_mode,
  // DMA handshake pins
  output var  logic        dma_request,
  output var  logic        dma_request_oe,
  input  wire logic        dma_acknowledge_in,
  output var  logic        dma_acknowledge,
  output var  logic        dma_acknowledge_oe,
  input  wire logic        end_of_transfer_in,
  // Drive interface pins
  output var  logic        drive_read_strobe,
  output var  logic        drive_write_strobe,
  output var  logic        drive_select_hi_n,
  output var  logic        drive_select_lo_n,
  output var  logic        drive_addr_bit2,
  output var  logic        drive_addr_bit1,
  output var  logic        drive_addr_bit0,
  input  wire logic [15:0] drive_data_in,
  output var  logic [15:0] drive_data_out,
  output var  logic        drive_data_oe
);

  pio_state_t  state;
  logic [7:0]  cnt;
  logic [7:0]  hw_cfg;
  logic [15:0] dma_cfg;
  logic        cfg_written;
  logic        cyc_wr;
  logic        cyc_data;
  logic [15:0] pio_wdata;
  logic        lo_held;
  logic [7:0]  lo_byte;
  logic        hi_held;
  logic [7:0]  hi_byte;
  logic [7:0]  data_window;
  logic [5:0]  pins;
  logic        is_data;
  logic        is_cmd;
  logic        take;
  logic        start_cyc;
  logic        quick;
  logic        swap_on;
  logic        pio_busy;
  logic [31:0] read_mux;
  logic [7:0]  strobe_run;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Request decode; a take happens once per request while waitrequest is up
  always_comb begin
    pins      = tf_pins(avs_address);                    // [R12] [R14]
    is_data   = avs_address == IDX_TF_DATA;
    is_cmd    = avs_address == IDX_TF_CMD;
    pio_busy  = state != ST_IDLE;
    take      = (avs_read | avs_write) & avs_waitrequest & ~pio_busy;
    start_cyc = take & pins[5]                           // [R16]
                & ~(avs_read & is_cmd)                   // [R21]
                & ~(avs_write & is_data & ~lo_held)      // [R15]
                & ~(avs_read & is_data & hi_held);       // [R15]
    quick     = take & ~start_cyc;
    // Reserved codes fall through to normal order
    swap_on   = xfer_dma_active & dma_cfg[CFG_WIDTH16]   // [R03]
                & (hw_cfg[HW_ENDIAN_HI:HW_ENDIAN_LO] == ENDIAN_SWAPPED); // [R22]
  end

  // Immediate read answers
  always_comb begin
    unique case (avs_address)
      IDX_HW_CFG:  read_mux = {24'h000000, hw_cfg};
      IDX_DMA_CFG: read_mux = {16'h0000, dma_cfg};
      IDX_STATUS:  read_mux = {29'h0, hi_held, lo_held, cfg_written};
      IDX_TF_CMD:  read_mux = {24'h000000, CMD_READ_VALUE}; // [R21]
      IDX_TF_DATA: read_mux = {24'h000000, data_window};   // [R15] [R18]
      default:     read_mux = 32'h00000000;
    endcase
  end

  // Configuration registers; both resets restore the documented values
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hw_cfg      <= HW_CFG_RESET;                       // [R08]
      dma_cfg     <= DMA_CFG_RESET;
      cfg_written <= 1'b0;
    end else if (bus_reset) begin
      hw_cfg      <= HW_CFG_RESET;                       // [R08]
      dma_cfg     <= DMA_CFG_RESET;
      cfg_written <= 1'b0;
    end else if (take & avs_write) begin
      if (avs_address == IDX_HW_CFG && avs_byteenable[0]) begin
        hw_cfg <= avs_writedata[7:0];                    // [R01]
      end
      if (avs_address == IDX_DMA_CFG) begin
        if (avs_byteenable[0]) begin
          dma_cfg[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          dma_cfg[15:8] <= avs_writedata[15:8];
        end
        cfg_written <= 1'b1;                             // [R20]
      end
    end
  end

  // PIO phase sequencer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cnt   <= 8'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start_cyc) begin                           // [R12]
            state <= ST_SETUP;
            cnt   <= 8'(SETUP_CYC - 8'h01);
          end
        end
        ST_SETUP: begin
          if (cnt == 8'h00) begin
            state <= ST_STROBE;
            cnt   <= 8'(STROBE_CYC - 8'h01);
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ST_STROBE: begin
          if (cnt == 8'h00) begin
            state <= ST_RECOVER;
            cnt   <= 8'(RECOVER_CYC - 8'h01);
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ST_RECOVER: begin
          if (cnt == 8'h00) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
      endcase
    end
  end

  // Cycle context, latched at start so the host request may not be relied on
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_wr            <= 1'b0;
      cyc_data          <= 1'b0;
      pio_wdata         <= 16'h0000;
      drive_select_hi_n <= 1'b1;
      drive_select_lo_n <= 1'b1;
      drive_addr_bit2   <= 1'b0;
      drive_addr_bit1   <= 1'b0;
      drive_addr_bit0   <= 1'b0;
    end else if (start_cyc) begin
      cyc_wr    <= avs_write;
      cyc_data  <= is_data;
      // Data word pairs the held low byte with this one
      pio_wdata <= is_data ? {avs_writedata[7:0], lo_byte}  // [R11] [R15]
                           : {8'h00, avs_writedata[7:0]};
      drive_select_hi_n <= pins[4];                      // [R13]
      drive_select_lo_n <= pins[3];                      // [R13]
      drive_addr_bit2   <= pins[2];
      drive_addr_bit1   <= pins[1];
      drive_addr_bit0   <= pins[0];
    end else if (state == ST_IDLE) begin
      drive_select_hi_n <= 1'b1;
      drive_select_lo_n <= 1'b1;
    end
  end

  // Host answers, byte pairing of the data register, data window
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      lo_held         <= 1'b0;
      lo_byte         <= 8'h00;
      hi_held         <= 1'b0;
      hi_byte         <= 8'h00;
      data_window     <= TF_DATA_RESET;                  // [R18]
    end else begin
      avs_waitrequest <= 1'b1;
      if (bus_reset) begin
        lo_held     <= 1'b0;
        hi_held     <= 1'b0;
        data_window <= TF_DATA_RESET;                    // [R18]
      end
      if (quick) begin
        avs_waitrequest <= 1'b0;
        if (avs_read) begin
          avs_readdata <= read_mux;
        end
        if (avs_write && is_data) begin                  // [R15]
          lo_byte     <= avs_writedata[7:0];
          lo_held     <= 1'b1;
          data_window <= avs_writedata[7:0];
        end
        if (avs_read && is_data) begin
          hi_held     <= 1'b0;
          data_window <= hi_byte;
        end
      end
      if (start_cyc && avs_write && is_data) begin
        lo_held     <= 1'b0;
        data_window <= avs_writedata[7:0];
      end
      // Sample while the read strobe pin is still active
      if (state == ST_STROBE && cnt == 8'h00 && !cyc_wr) begin
        avs_readdata <= {24'h000000, drive_data_in[7:0]}; // [R23]
        if (cyc_data) begin
          hi_byte     <= drive_data_in[15:8];            // [R11]
          hi_held     <= 1'b1;
          data_window <= drive_data_in[15:8];            // [R15]
        end
      end
      if (state == ST_RECOVER && cnt == 8'h00) begin
        avs_waitrequest <= 1'b0;                         // [R23]
      end
    end
  end

  // Pin levels; engine strobes share the pins with PIO cycles
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_read_strobe  <= 1'b1;
      drive_write_strobe <= 1'b1;
      dma_request        <= 1'b1;
      dma_request_oe     <= 1'b0;
      dma_acknowledge    <= 1'b1;
      dma_acknowledge_oe <= 1'b0;
      eot_seen           <= 1'b0;
      ack_seen           <= 1'b0;
      drive_data_out     <= 16'h0000;
      drive_data_oe      <= 1'b0;
      buf_in_data        <= 16'h0000;
    end else begin
      drive_read_strobe  <=
        ((state == ST_STROBE && !cyc_wr) | eng_rd)
        ~^ hw_cfg[HW_RD_LVL];                            // [R10]
      drive_write_strobe <=
        ((state == ST_STROBE && cyc_wr) | eng_wr)
        ~^ hw_cfg[HW_WR_LVL];                            // [R09]
      dma_request        <= eng_req ~^ hw_cfg[HW_REQ_LVL];   // [R08]
      dma_request_oe     <= cfg_written;                 // [R20]
      dma_acknowledge    <= eng_ack ~^ hw_cfg[HW_ACK_LVL];   // [R07]
      dma_acknowledge_oe <= hw_cfg[HW_MASTER];           // [R06]
      // End input ignored in master role
      eot_seen <= !hw_cfg[HW_MASTER]                     // [R05]
                  && (end_of_transfer_in == hw_cfg[HW_EOT_LVL]);
      ack_seen <= !hw_cfg[HW_MASTER]
                  && (dma_acknowledge_in == hw_cfg[HW_ACK_LVL]);
      // PIO data never swapped; it owns the bus while busy
      if (pio_busy) begin
        drive_data_out <= pio_wdata;                     // [R11]
        drive_data_oe  <= cyc_wr;
      end else begin
        drive_data_out <= swap_on ? swap16(eng_out_data) // [R02]
                                  : eng_out_data;
        drive_data_oe  <= eng_out_en;
      end
      buf_in_data <= swap_on ? swap16(drive_data_in)     // [R02] [R03]
                             : drive_data_in;
    end
  end

  // Mode outputs for the DMA engine
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      master_mode    <= 1'b0;
      width16        <= 1'b0;
      disk_core_mode <= 1'b0;
    end else begin
      master_mode    <= hw_cfg[HW_MASTER];               // [R06]
      width16        <= dma_cfg[CFG_WIDTH16];
      disk_core_mode <= dma_cfg[CFG_CORE_MODE];
    end
  end

  // Strobe phase length, for checking only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_run <= 8'h00;
    end else begin
      strobe_run <= (state == ST_STROBE) ? strobe_run + 8'h01 : 8'h00;
    end
  end

  sequence s_tf_take;
    take && pins[5];
  endsequence

  sequence s_cmd_read;
    s_tf_take ##0 avs_read && is_cmd;
  endsequence

  sequence s_lo_write;
    s_tf_take ##0 avs_write && is_data && !lo_held;
  endsequence

  AST_HW_RESET: assert property (bus_reset |=> hw_cfg == HW_CFG_RESET) // [R08]
    else $error("bus setup register not restored by bus reset");
  AST_REQ_OE: assert property (dma_request_oe |-> $past(cfg_written)) // [R20]
    else $error("request pin driven before configuration write");
  AST_SWAP: assert property ((swap_on && !bus_reset) |=> // [R02]
      buf_in_data == swap16($past(drive_data_in)))
    else $error("swapped byte order not applied");
  AST_NO_SWAP: assert property (!swap_on |=> // [R22]
      buf_in_data == $past(drive_data_in))
    else $error("bytes exchanged outside swapped DMA mode");
  AST_EOT_MASTER: assert property (hw_cfg[HW_MASTER] |=> !eot_seen) // [R05]
    else $error("end input honoured in master role");
  AST_CMD_READ: assert property (s_cmd_read |=> // [R21]
      !avs_waitrequest && avs_readdata[7:0] == CMD_READ_VALUE
      && state == ST_IDLE)
    else $error("command read not answered with all ones");
  AST_LOW_BYTE: assert property (s_lo_write |=> // [R15]
      !avs_waitrequest && state == ST_IDLE && lo_held)
    else $error("first data byte started a drive cycle");
  AST_PENDING: assert property ((state != ST_IDLE) |-> avs_waitrequest) // [R23]
    else $error("host released before drive cycle ended");
  AST_PIN_MAP: assert property (s_tf_take ##0 start_cyc |=> // [R13]
      {drive_select_hi_n, drive_select_lo_n, drive_addr_bit2,
       drive_addr_bit1, drive_addr_bit0} == $past(pins[4:0]))
    else $error("drive select and address pins mismatch");
  AST_STROBE_LEN: assert property ((state == ST_STROBE && cnt == 8'h00) // [R12]
      |-> strobe_run == 8'(STROBE_CYC - 8'h01))
    else $error("strobe phase length wrong");
  AST_WORD_OUT: assert property ((state == ST_STROBE && cyc_wr) // [R11]
      |-> drive_data_oe && drive_data_out == pio_wdata)
    else $error("drive write word not on bus during strobe");

endmodule
`default_nettype wire

// ===== tb/drive_peer_model.sv
// Purpose: Behavioural drive that answers PIO and DMA strobes
// Assumes: Strobe active levels are handed over by the bench
// Notes:   Released data lines show the inverse of the last word read
`timescale 1ns/1ns
`default_nettype none
module drive_peer_model (
  // Clock and strobe levels
  input  wire logic        core_clk,
  input  wire logic        rd_lvl,
  input  wire logic        wr_lvl,
  // Drive pins
  input  wire logic        rd_strobe,
  input  wire logic        wr_strobe,
  input  wire logic        sel_hi_n,
  input  wire logic        sel_lo_n,
  input  wire logic [2:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wdata_oe,
  output logic      [15:0] rdata,
  // Observation
  output logic      [4:0]  last_idx,
  output logic      [15:0] last_word,
  output logic      [7:0]  wr_cnt,
  output logic      [7:0]  rd_cnt
);
  logic [15:0] regs [32];
  logic [15:0] held;
  logic [4:0]  idx;
  logic        rd_act;
  logic        wr_act;
  logic        rd_was;
  logic        wr_was;

  // Register picked by selects and address; idle selects mean DMA data
  assign idx = (sel_hi_n & sel_lo_n) ? 5'h10 : {sel_hi_n, sel_lo_n, addr};
  assign rd_act = (rd_strobe === rd_lvl);
  assign wr_act = (wr_strobe === wr_lvl);
  // Never repeat the last word once released, so stale data cannot pass
  assign rdata = rd_act ? regs[idx] : ~held;

  initial begin
    wr_cnt = 8'h00;
    rd_cnt = 8'h00;
    held = 16'h0000;
    foreach (regs[i]) regs[i] = 16'h0000;
    rd_was = 1'b0;
    wr_was = 1'b0;
  end

  // Latch writes while strobed, count cycles on the trailing strobe edge
  always @(posedge core_clk) begin
    rd_was <= rd_act;
    wr_was <= wr_act;
    if (rd_act) held <= regs[idx];
    if (wr_act && wdata_oe) begin
      regs[idx] <= wdata;
      last_idx <= idx;
      last_word <= wdata;
    end
    if (rd_was && !rd_act) rd_cnt <= rd_cnt + 8'h01;
    if (wr_was && !wr_act) wr_cnt <= wr_cnt + 8'h01;
  end
endmodule
`default_nettype wire

// ===== tb/dma_tf_bridge_tb.sv
// Purpose: Self-checking bench for the DMA setup and drive register bridge
// Assumes: Short PIO phases; the drive model sees the strobe levels set
// Notes:   Each scenario is a task that drives and judges on its own
`timescale 1ns/1ns
`default_nettype none
module dma_tf_bridge_tb;
  import dma_tf_pkg::*;
  // Stimulus
  logic        core_clk = 1'b0, reset_n = 1'b0, bus_reset = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        xfer_dma_active = 1'b0, eng_req = 1'b0, eng_ack = 1'b0;
  logic        eng_rd = 1'b0, lvl_rd = 1'b0, lvl_wr = 1'b0;
  logic        eng_wr = 1'b0, eng_out_en = 1'b0;
  logic [15:0] eng_out_data = 16'h0000;
  logic        dma_acknowledge_in = 1'b0, end_of_transfer_in = 1'b0;
  // Observed
  logic [31:0] avs_readdata;
  logic [15:0] buf_in_data, drive_data_in, drive_data_out, last_word;
  logic        avs_waitrequest, eot_seen, ack_seen, master_mode, width16;
  logic        disk_core_mode, dma_request, dma_request_oe, dma_acknowledge;
  logic        dma_acknowledge_oe, drive_read_strobe, drive_write_strobe;
  logic        drive_select_hi_n, drive_select_lo_n, drive_data_oe;
  logic        drive_addr_bit2, drive_addr_bit1, drive_addr_bit0;
  logic [4:0]  last_idx;
  logic [7:0]  wr_cnt, rd_cnt, q;
  int          error_cnt = 0, samples_checked = 0, cycles = 0;
  // Drive registers in write order, command last
  logic [7:0]  tf_addr [9] = '{8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d,
                              8'h4e, 8'h4f, 8'h44};
  logic [4:0]  tf_idx [9] = '{5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16,
                             5'h0e, 5'h0f, 5'h17};
  logic [7:0]  pin_cfg [4] = '{8'h00, 8'h2c, 8'h17, 8'h3f};

  dma_tf_bridge #(.SETUP_CYC(8'h02), .STROBE_CYC(8'h03),
    .RECOVER_CYC(8'h02)) dma_tf_bridge_i (
    .core_clk, .reset_n, .bus_reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .xfer_dma_active, .eng_req, .eng_ack, .eng_rd, .eng_wr,
    .eng_out_en, .eng_out_data, .buf_in_data, .eot_seen,
    .ack_seen, .master_mode, .width16, .disk_core_mode, .dma_request,
    .dma_request_oe, .dma_acknowledge_in, .dma_acknowledge,
    .dma_acknowledge_oe, .end_of_transfer_in, .drive_read_strobe,
    .drive_write_strobe, .drive_select_hi_n, .drive_select_lo_n,
    .drive_addr_bit2, .drive_addr_bit1, .drive_addr_bit0, .drive_data_in,
    .drive_data_out, .drive_data_oe);

  drive_peer_model drive_peer_model_i (
    .core_clk, .rd_lvl(lvl_rd), .wr_lvl(lvl_wr),
    .rd_strobe(drive_read_strobe), .wr_strobe(drive_write_strobe),
    .sel_hi_n(drive_select_hi_n), .sel_lo_n(drive_select_lo_n),
    .addr({drive_addr_bit2, drive_addr_bit1, drive_addr_bit0}),
    .wdata(drive_data_out), .wdata_oe(drive_data_oe),
    .rdata(drive_data_in), .last_idx, .last_word, .wr_cnt, .rd_cnt);

  // Clock and hang guard
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude;
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // One Avalon access; holds until waitrequest is seen low, q gets data
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [15:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, d};
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 16'h0000);
    chk(16'(q), 16'(exp));
  endtask

  task automatic t_reset;
    chk(16'(dma_request_oe), 16'h0000);
    chk(16'({drive_select_hi_n, drive_select_lo_n}), 16'h0003);
    rd(IDX_HW_CFG, 8'h04);
    bus(1'b1, IDX_DMA_CFG, 16'h2001);
    repeat (2) @(posedge core_clk);
    chk(16'(dma_request_oe), 16'h0001);
    chk(16'({disk_core_mode, width16}), 16'h0003);
  endtask

  // Polarity, role and end-of-transfer honouring per configuration
  task automatic t_pins;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = pin_cfg[i];
      bus(1'b1, IDX_HW_CFG, {8'h00, v});
      rd(IDX_HW_CFG, v);
      eng_req <= 1'b1;
      eng_wr <= 1'b0;
      eng_ack <= 1'b1;
      xfer_dma_active <= 1'b1;
      dma_acknowledge_in <= v[3];
      end_of_transfer_in <= v[5];
      repeat (3) @(posedge core_clk);
      chk(16'({dma_request, dma_acknowledge}), 16'({v[2], v[3]}));
      chk(16'({dma_acknowledge_oe, master_mode}), {14'h0, {2{v[4]}}});
      chk(16'({eot_seen, ack_seen}), {14'h0, {2{!v[4]}}});
      chk(16'({drive_read_strobe, drive_write_strobe}),
          16'({!v[0], !v[1]}));
      eng_req <= 1'b0;
      eng_wr <= 1'b1;
      end_of_transfer_in <= !v[5];
      repeat (3) @(posedge core_clk);
      chk(16'({dma_request, eot_seen}), 16'({!v[2], 1'b0}));
      chk(16'(drive_write_strobe), 16'(v[1]));
    end
    xfer_dma_active <= 1'b0;
    eng_ack <= 1'b0;
    eng_wr <= 1'b0;
  endtask

  // Every drive register but data at both strobe polarities, then read back all but command
  task automatic t_map;
    logic [7:0] n;
    logic [7:0] b;
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, IDX_HW_CFG, (p == 1) ? 16'h0007 : 16'h0004);
      lvl_rd <= (p == 1);
      lvl_wr <= (p == 1);
      // Let the model's strobe view settle before counting
      repeat (3) @(posedge core_clk);
      n = wr_cnt;
      for (int k = 0; k < 9; k++) begin
        b = 8'h50 + 8'(k) + 8'(16 * p);
        bus(1'b1, tf_addr[k], {8'h00, b});
        chk(16'(last_idx), 16'(tf_idx[k]));
        chk(last_word, {8'h00, b});
      end
      chk(16'(wr_cnt), 16'(n) + 16'h0009);
      n = rd_cnt;
      for (int k = 0; k < 8; k++) begin
        rd(tf_addr[k], 8'h50 + 8'(k) + 8'(16 * p));
      end
      chk(16'(rd_cnt), 16'(n) + 16'h0008);
      rd(IDX_TF_CMD, 8'hff);
      chk(16'(rd_cnt), 16'(n) + 16'h0008);
    end
    bus(1'b1, IDX_HW_CFG, 16'h0004);
    lvl_rd <= 1'b0;
    lvl_wr <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // Data register pairing, low byte first, one 16-bit cycle
  task automatic t_data;
    logic [7:0] n;
    n = wr_cnt;
    bus(1'b1, IDX_TF_DATA, 16'h0034);
    chk(16'(wr_cnt), 16'(n));
    bus(1'b1, IDX_TF_DATA, 16'h0012);
    chk(16'(wr_cnt), 16'(n) + 16'h0001);
    chk(last_word, 16'h1234);
    chk(16'(last_idx), 16'h0010);
    n = rd_cnt;
    rd(IDX_TF_DATA, 8'h34);
    chk(16'(rd_cnt), 16'(n) + 16'h0001);
    rd(IDX_TF_DATA, 8'h12);
    chk(16'(rd_cnt), 16'(n) + 16'h0001);
  endtask

  // Byte order on DMA reads for every swap code, last code swapped
  task automatic t_swap;
    logic [1:0] c;
    eng_rd <= 1'b1;
    eng_out_en <= 1'b1;
    eng_out_data <= 16'habcd;
    xfer_dma_active <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i) ^ 2'b10;
      bus(1'b1, IDX_HW_CFG, {8'h00, c, 6'h04});
      repeat (3) @(posedge core_clk);
      chk(buf_in_data, (c == 2'b01) ? 16'h3412 : 16'h1234);
      chk(drive_data_out, (c == 2'b01) ? 16'hcdab : 16'habcd);
    end
    xfer_dma_active <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(buf_in_data, 16'h1234);
    chk(drive_data_out, 16'habcd);
    eng_rd <= 1'b0;
    eng_out_en <= 1'b0;
    bus(1'b1, IDX_HW_CFG, 16'h0004);
  endtask

  // Bus reset mid-pair: setup back to default, held low byte dropped
  task automatic t_busrst;
    logic [7:0] n;
    bus(1'b1, IDX_HW_CFG, 16'h00f4);
    n = wr_cnt;
    bus(1'b1, IDX_TF_DATA, 16'h0077);
    bus_reset <= 1'b1;
    @(posedge core_clk);
    bus_reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(16'(dma_request_oe), 16'h0000);
    rd(IDX_HW_CFG, 8'h04);
    bus(1'b1, IDX_DMA_CFG, 16'h2001);
    bus(1'b1, IDX_TF_DATA, 16'h0066);
    chk(16'(wr_cnt), 16'(n));
    bus(1'b1, IDX_TF_DATA, 16'h0055);
    chk(last_word, 16'h5566);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_pins();
    t_map();
    t_data();
    t_swap();
    t_busrst();
    conclude();
  end
endmodule
`default_nettype wire
